// ### pll_a_cfg_pkg.sv
// constants, layouts and types for the first synthesizer's configuration bank
// assumes a 32-bit apb slave with one byte register per aligned word
package pll_a_cfg_pkg;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_INT_DIV_HIGH  = 8'h3A;
    localparam logic [7:0] IDX_INT_DIV_LOW   = 8'h3B;
    localparam logic [7:0] IDX_FRAC_NUM_HIGH = 8'h3C;
    localparam logic [7:0] IDX_FRAC_NUM_MID  = 8'h3D;
    localparam logic [7:0] IDX_FRAC_NUM_LOW  = 8'h3E;
    localparam logic [7:0] IDX_FRAC_DEN_HIGH = 8'h3F;
    localparam logic [7:0] IDX_FRAC_DEN_MID  = 8'h40;
    localparam logic [7:0] IDX_FRAC_DEN_LOW  = 8'h41;
    localparam logic [7:0] IDX_MOD_CTRL      = 8'h42;
    localparam logic [7:0] IDX_FILTER_RES_2  = 8'h43;
    localparam logic [7:0] IDX_FILTER_CAP_1  = 8'h44;
    localparam logic [7:0] IDX_FILTER_RES_3  = 8'h45;

    // storage slots, slot = index - first index
    localparam int          NUM_REGS    = 12;
    localparam logic [3:0]  SLOT_NDIV_H = 4'h0;
    localparam logic [3:0]  SLOT_NDIV_L = 4'h1;
    localparam logic [3:0]  SLOT_NUM_H  = 4'h2;
    localparam logic [3:0]  SLOT_NUM_M  = 4'h3;
    localparam logic [3:0]  SLOT_NUM_L  = 4'h4;
    localparam logic [3:0]  SLOT_DEN_H  = 4'h5;
    localparam logic [3:0]  SLOT_DEN_M  = 4'h6;
    localparam logic [3:0]  SLOT_DEN_L  = 4'h7;
    localparam logic [3:0]  SLOT_MODC   = 4'h8;
    localparam logic [3:0]  SLOT_R2     = 4'h9;
    localparam logic [3:0]  SLOT_C1     = 4'hA;
    localparam logic [3:0]  SLOT_R3     = 4'hB;

    // reset values, slot 11 first
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
        8'h00, 8'h00, 8'h24, 8'h0C, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h66, 8'h00};
    // writable bits, reserved bits are zero here
    localparam logic [NUM_REGS-1:0][7:0] REG_WMASK = {
        8'h7F, 8'h07, 8'h3F, 8'h0F, 8'hFF, 8'hFF,
        8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h0F};

    // field positions inside the modulator and filter registers
    localparam int DITHER_LSB   = 2;
    localparam int ORDER_LSB    = 0;
    localparam int R3_CODE_LSB  = 1;
    localparam int FRAC_MODE_BIT = 0;

    // modulator order and dither codes
    localparam logic [1:0] ORDER_INTEGER = 2'h0;
    localparam logic [1:0] DITHER_WEAK   = 2'h0;
    localparam logic [1:0] DITHER_MEDIUM = 2'h1;
    localparam logic [1:0] DITHER_STRONG = 2'h2;
    localparam logic [1:0] DITHER_OFF    = 2'h3;

    // first capacitor value in pF: base plus step times code
    localparam logic [8:0] CAP_BASE_PF = 9'h005;
    localparam logic [8:0] CAP_STEP_PF = 9'h032;

    // effective divide value after reset, matches the reset divider bytes
    localparam logic [12:0] DIV_RESET = 13'h0066;

    // apb slave phases
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } apb_state_t;

endpackage

// ### div_cfg_if.sv
// carries the divider settings to the fractional sequencer and its result back
// assumes both ends run on the same apb clock
`timescale 1ns/1ps
interface div_cfg_if;
    logic [11:0] int_div;    // integer feedback divider
    logic [21:0] num;        // fraction numerator
    logic [21:0] den;        // fraction denominator
    logic [1:0]  order;      // modulator order
    logic [12:0] div_value;  // divide value of this step
    logic        carry;      // fraction overflowed this step

    modport cfg (output int_div, num, den, order, input div_value, carry);
    modport seq (input int_div, num, den, order, output div_value, carry);
endinterface

// ### frac_div_seq.sv
// per-cycle feedback divide value from integer part and fraction
// assumes settings come from flops on the same clock
`timescale 1ns/1ps
module frac_div_seq
    import pll_a_cfg_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    div_cfg_if.seq    dif
);
    typedef struct packed {
        logic [21:0] acc;        // fraction accumulator
        logic [12:0] div_value;  // divide value presented
        logic        carry;      // overflow of this step
    } seq_state_t;

    localparam seq_state_t SEQ_RESET = '{acc: 22'h000000, div_value: DIV_RESET, carry: 1'b0};

    seq_state_t s_reg;
    seq_state_t s_next;

    // codes 0 and 1 both divide by one
    function automatic logic [12:0] int_ratio(input logic [11:0] n);
        int_ratio = (n == 12'h000) ? 13'h0001 : {1'b0, n};
    endfunction

    // accumulate numerator modulo denominator, carry adds one to the divide
    always_comb begin
        logic [22:0] sum;
        sum    = {1'b0, s_reg.acc} + {1'b0, dif.num};
        s_next = s_reg;
        if (dif.order == ORDER_INTEGER || dif.den == 22'h000000) begin
            // integer alone; a zero denominator would make no sense
            s_next.acc       = 22'h000000;
            s_next.carry     = 1'b0;
            s_next.div_value = int_ratio(dif.int_div);
        end else if (sum >= {1'b0, dif.den}) begin
            // average ends at int plus num over den
            s_next.acc       = 22'(sum - {1'b0, dif.den});
            s_next.carry     = 1'b1;
            s_next.div_value = int_ratio(dif.int_div) + 13'h0001;
        end else begin
            s_next.acc       = sum[21:0];
            s_next.carry     = 1'b0;
            s_next.div_value = int_ratio(dif.int_div);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= SEQ_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dif.div_value = s_reg.div_value;
    assign dif.carry     = s_reg.carry;
endmodule

// ### pll_a_loop_cfg.sv
// configuration bank of the first synthesizer behind an apb slave
// assumes an apb master on pclk; one byte register per aligned word
`timescale 1ns/1ps
module pll_a_loop_cfg
    import pll_a_cfg_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic      [11:0]          integer_feedback_divider,
    output logic      [21:0]          fraction_numerator,
    output logic      [21:0]          fraction_denominator,
    output logic      [1:0]           dither_select,
    output logic                      dither_on,
    output logic      [1:0]           modulator_order,
    output logic                      fractional_division,
    output logic      [5:0]           filter_second_resistor_code,
    output logic      [2:0]           filter_first_capacitor_code,
    output logic      [8:0]           filter_first_capacitor_pf,
    output logic      [5:0]           filter_third_resistor_code,
    output logic                      filter_fractional_mode,
    output logic      [12:0]          feedback_divide_value,
    output logic                      feedback_carry
);
    import pll_a_cfg_pkg::*;

    // whole state of the slave and the bank
    typedef struct packed {
        apb_state_t                  ph;        // apb phase
        logic                        pready;    // answer in access phase
        logic                        pslverr;   // unmapped or misaligned
        logic [31:0]                 prdata;    // read data
        logic [3:0]                  slot;      // slot caught at setup
        logic [NUM_REGS-1:0][7:0]    regs;      // register storage
        logic [8:0]                  cap_pf;    // first capacitor in pF
        logic                        dither_on; // dither enabled
        logic                        frac_div;  // fractional division
    } state_t;

    // reset image; derived fields agree with the reset register bytes
    localparam state_t S_RESET = '{
        ph:        ST_IDLE,
        pready:    1'b0,
        pslverr:   1'b0,
        prdata:    32'h00000000,
        slot:      4'h0,
        regs:      REG_RESET,
        cap_pf:    CAP_BASE_PF,
        dither_on: 1'b0,
        frac_div:  1'b0
    };

    state_t s_reg;      // registered state
    state_t s_next;     // next state

    div_cfg_if dif ();  // link to the fractional sequencer

    // true when the byte address names a register of this bank
    function automatic logic addr_hit(input logic [11:0] a);
        logic [7:0] idx;
        idx      = a[9:2];
        addr_hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
                   (idx >= IDX_INT_DIV_HIGH) && (idx <= IDX_FILTER_RES_3);
    endfunction

    // storage slot of a byte address, valid only when addr_hit holds
    function automatic logic [3:0] addr_slot(input logic [11:0] a);
        logic [7:0] diff;
        diff      = a[9:2] - IDX_INT_DIV_HIGH;
        addr_slot = diff[3:0];
    endfunction

    // capacitance in pF of a first capacitor code
    function automatic logic [8:0] cap_pf_of(input logic [2:0] code);
        cap_pf_of = CAP_BASE_PF + CAP_STEP_PF * {6'h00, code};
    endfunction

    // apb phases, register writes and derived decodes
    always_comb begin
        logic [7:0] wbyte;
        logic [3:0] cslot;
        logic [1:0] dsel;
        logic [1:0] ord;
        wbyte  = 8'h00;
        cslot  = addr_slot(paddr);
        dsel   = 2'h0;
        ord    = 2'h0;
        s_next = s_reg;
        unique case (s_reg.ph)
            ST_IDLE: begin
                // setup phase: decode, answer in the first access cycle
                if (psel && !penable) begin
                    s_next.ph      = ST_RESP;
                    s_next.pready  = 1'b1;
                    s_next.slot    = cslot;
                    s_next.pslverr = !addr_hit(paddr);
                    if (addr_hit(paddr) && !pwrite) begin
                        // stored bytes hold zero in reserved bits
                        s_next.prdata = {24'h000000, s_reg.regs[cslot]};
                    end else begin
                        s_next.prdata = 32'h00000000;
                    end
                end
            end
            ST_RESP: begin
                // access completes on this edge; pready is high now
                if (psel && penable) begin
                    s_next.ph      = ST_IDLE;
                    s_next.pready  = 1'b0;
                    s_next.pslverr = 1'b0;
                    s_next.prdata  = 32'h00000000;
                    // only the low lane carries a register
                    if (pwrite && !s_reg.pslverr && pstrb[0]) begin
                        wbyte = pwdata[7:0] & REG_WMASK[s_reg.slot];
                        s_next.regs[s_reg.slot] = wbyte;
                    end
                end else begin
                    // master dropped the transfer; go back quietly
                    s_next.ph      = ST_IDLE;
                    s_next.pready  = 1'b0;
                    s_next.pslverr = 1'b0;
                end
            end
            default: begin
                // illegal one-hot code: recover to idle
                s_next.ph     = ST_IDLE;
                s_next.pready = 1'b0;
            end
        endcase

        // decodes follow the new bytes so outputs agree on the same edge
        dsel              = s_next.regs[SLOT_MODC][DITHER_LSB +: 2];
        ord               = s_next.regs[SLOT_MODC][ORDER_LSB +: 2];
        s_next.dither_on  = (dsel != DITHER_OFF);
        s_next.frac_div   = (ord != ORDER_INTEGER);
        s_next.cap_pf     = cap_pf_of(s_next.regs[SLOT_C1][2:0]);
    end

    // the only clocked process
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= S_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // divider settings toward the sequencer, all from flops
    assign dif.int_div = {s_reg.regs[SLOT_NDIV_H][3:0], s_reg.regs[SLOT_NDIV_L]};
    assign dif.num     = {s_reg.regs[SLOT_NUM_H][5:0], s_reg.regs[SLOT_NUM_M],
                          s_reg.regs[SLOT_NUM_L]};
    assign dif.den     = {s_reg.regs[SLOT_DEN_H][5:0], s_reg.regs[SLOT_DEN_M],
                          s_reg.regs[SLOT_DEN_L]};
    assign dif.order   = s_reg.regs[SLOT_MODC][ORDER_LSB +: 2];

    // sequencer; one step per clock, reacts one edge after a write
    frac_div_seq u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .dif     (dif.seq)
    );

    // apb answer
    assign prdata  = s_reg.prdata;
    assign pready  = s_reg.pready;
    assign pslverr = s_reg.pslverr;

    // configuration fields straight from the storage flops
    assign integer_feedback_divider    = dif.int_div;
    assign fraction_numerator          = dif.num;
    assign fraction_denominator        = dif.den;
    assign dither_select               = s_reg.regs[SLOT_MODC][DITHER_LSB +: 2];
    assign dither_on                   = s_reg.dither_on;
    assign modulator_order             = s_reg.regs[SLOT_MODC][ORDER_LSB +: 2];
    assign fractional_division         = s_reg.frac_div;
    assign filter_second_resistor_code = s_reg.regs[SLOT_R2][5:0];
    assign filter_first_capacitor_code = s_reg.regs[SLOT_C1][2:0];
    assign filter_first_capacitor_pf   = s_reg.cap_pf;
    assign filter_third_resistor_code  = s_reg.regs[SLOT_R3][R3_CODE_LSB +: 6];
    // software keeps this bit in step with the order field
    assign filter_fractional_mode      = s_reg.regs[SLOT_R3][FRAC_MODE_BIT];

    // divide value and overflow come from the sequencer's flops
    assign feedback_divide_value       = dif.div_value;
    assign feedback_carry              = dif.carry;
endmodule

// ### pll_a_loop_cfg_assertions.sv
// concurrent checks on the first synthesizer configuration bank ports
// assumes one clock pclk and asynchronous active-low presetn
`timescale 1ns/1ps
module pll_a_loop_cfg_assertions (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [11:0] integer_feedback_divider,
    input logic [21:0] fraction_numerator,
    input logic [1:0]  dither_select,
    input logic        dither_on,
    input logic [1:0]  modulator_order,
    input logic        fractional_division,
    input logic [2:0]  filter_first_capacitor_code,
    input logic [8:0]  filter_first_capacitor_pf,
    input logic [12:0] feedback_divide_value,
    input logic        feedback_carry
);
    // one domain, so clock and reset are given once
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // zero wait states: a setup is answered in the very next cycle
    a_ready_after_setup: assert property (psel && !penable && !pready |=> pready)
        else $error("setup not answered next cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flagged without ready");
    a_err_unmapped: assert property (psel && !penable && !pready && paddr == 12'h118 |=> pslverr)
        else $error("unmapped address accepted");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    // a completed strobed write to the divider low byte lands on the next edge
    a_div_low_write: assert property (psel && penable && pready && pwrite && pstrb[0] && !pslverr
        && paddr == 12'h0EC |=> integer_feedback_divider[7:0] == $past(pwdata[7:0]))
        else $error("divider low byte not written");
    a_num_high_write: assert property (psel && penable && pready && pwrite && pstrb[0] && !pslverr
        && paddr == 12'h0F0 |=> fraction_numerator[21:16] == $past(pwdata[5:0]))
        else $error("numerator high bits not written");
    a_dither_flag: assert property (dither_on == (dither_select != 2'h3))
        else $error("dither flag disagrees with select");
    a_order_frac: assert property (fractional_division == (modulator_order != 2'h0))
        else $error("fractional flag disagrees with order");
    a_cap_value: assert property (filter_first_capacitor_pf ==
        9'h005 + 9'h032 * {6'h00, filter_first_capacitor_code})
        else $error("capacitor value wrong");
    // integer order divides by the integer value alone, one cycle later
    a_int_value: assert property (modulator_order == 2'h0 && integer_feedback_divider != 12'h000
        |=> feedback_divide_value == {1'b0, $past(integer_feedback_divider)})
        else $error("integer mode divide value wrong");
    a_int_no_carry: assert property (modulator_order == 2'h0 |=> !feedback_carry)
        else $error("carry in integer mode");
endmodule

bind pll_a_loop_cfg pll_a_loop_cfg_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .integer_feedback_divider(integer_feedback_divider),
    .fraction_numerator(fraction_numerator), .dither_select(dither_select), .dither_on(dither_on),
    .modulator_order(modulator_order), .fractional_division(fractional_division),
    .filter_first_capacitor_code(filter_first_capacitor_code),
    .filter_first_capacitor_pf(filter_first_capacitor_pf),
    .feedback_divide_value(feedback_divide_value), .feedback_carry(feedback_carry));

// ### pll_a_loop_cfg_bench.sv
// self-checking bench for the first synthesizer configuration bank
// assumes byte address four times the index; waits for pready however long it takes
`timescale 1ns/1ps
module pll_a_loop_cfg_bench;
    logic        pclk = 1'b0;    // 200 MHz bus clock
    logic        presetn = 1'b0; // held low for ten cycles
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] int_div;
    logic [21:0] num;
    logic [21:0] den;
    logic [1:0]  dsel;
    logic        d_on;
    logic [1:0]  order;
    logic        frac_div;
    logic [5:0]  r2;
    logic [2:0]  c1;
    logic [8:0]  c1_pf;
    logic [5:0]  r3;
    logic        fmode;
    logic [12:0] fdv;
    logic        carry;
    logic [31:0] rdat;           // data taken at the completing edge
    logic        rerr;           // error taken at the completing edge
    int          failures = 0;
    int          checks = 0;
    int          cycles = 0;
    // expected reset values and writable masks, index 0x3A first
    logic [7:0] rst_v [12] = '{8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h24, 8'h00, 8'h00};
    logic [7:0] msk_v [12] = '{8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h3F, 8'h07, 8'h7F};
    logic [11:0] bad_a [4] = '{12'h0E4, 12'h0ED, 12'h4EC, 12'h118};

    pll_a_loop_cfg dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .integer_feedback_divider(int_div), .fraction_numerator(num), .fraction_denominator(den),
        .dither_select(dsel), .dither_on(d_on), .modulator_order(order), .fractional_division(frac_div),
        .filter_second_resistor_code(r2), .filter_first_capacitor_code(c1), .filter_first_capacitor_pf(c1_pf),
        .filter_third_resistor_code(r3), .filter_fractional_mode(fmode), .feedback_divide_value(fdv),
        .feedback_carry(carry));

    // 5 ns period
    always #2.5 pclk = ~pclk;

    // hang guard, far above the roughly 280 cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // one apb transfer; the request stands until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // answer is read as it stood at the edge, before the slave clears it
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // let derived outputs settle before anyone looks at them
        @(negedge pclk);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, {24'h000000, d}, 4'hF);
    endtask

    task automatic rd(input logic [7:0] i);
        apb(1'b0, {2'b00, i, 2'b00}, 32'h00000000, 4'hF);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 12; i++) begin
            rd(8'h3A + 8'(i));
            chk(rdat, {24'h000000, rst_v[i]});
        end
        chk({23'h0, c1_pf}, 32'h00000005);
        chk({30'h0, d_on, frac_div}, 32'h00000000);
        $display("test reset values done");
    endtask

    // all ones everywhere: reserved bits must read back zero
    task automatic t_mask;
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, {2'b00, 8'h3A + 8'(i), 2'b00}, 32'hFFFFFFFF, 4'hF);
            rd(8'h3A + 8'(i));
            chk(rdat, {24'h000000, msk_v[i]});
        end
        chk({20'h0, int_div}, 32'h00000FFF);
        chk({10'h0, num}, 32'h003FFFFF);
        chk({10'h0, den}, 32'h003FFFFF);
        chk({26'h0, r2}, 32'h0000003F);
        chk({26'h0, r3}, 32'h0000003F);
        chk({31'h0, fmode}, 32'h00000001);
        // write without the low strobe is dropped
        apb(1'b1, 12'h0EC, 32'h00000000, 4'hE);
        chk({20'h0, int_div}, 32'h00000FFF);
        wr(8'h3B, 8'h34);
        wr(8'h3A, 8'h12);
        chk({20'h0, int_div}, 32'h00000234);
        $display("test masks done");
    endtask

    task automatic t_err;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, bad_a[i], 32'h00000000, 4'hF);
            chk({31'h0, rerr}, 32'h00000001);
            apb(1'b0, bad_a[i], 32'h00000000, 4'hF);
            chk(rdat, 32'h00000000);
        end
        rd(8'h3B);
        chk(rdat, 32'h00000034);
        $display("test refused addresses done");
    endtask

    task automatic t_modes;
        for (int c = 0; c < 16; c++) begin
            wr(8'h42, 8'(c));
            chk({28'h0, dsel, order}, 32'(c));
            chk({30'h0, d_on, frac_div}, {30'h0, c[3:2] != 2'h3, c[1:0] != 2'h0});
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h44, 8'(c));
            chk({29'h0, c1}, 32'(c));
            chk({23'h0, c1_pf}, 32'(5 + 50 * c));
        end
        $display("test modes and capacitor done");
    endtask

    // divide by 10 + 1/4: two carries in every eight cycles
    task automatic t_frac;
        int sum;
        int ncar;
        sum = 0;
        ncar = 0;
        // integer order first clears whatever the accumulator held
        wr(8'h42, 8'h0C);
        wr(8'h3A, 8'h00);
        wr(8'h3B, 8'h0A);
        for (int i = 0; i < 6; i++) begin
            wr(8'h3C + 8'(i), (i == 2) ? 8'h01 : (i == 5) ? 8'h04 : 8'h00);
        end
        wr(8'h45, 8'h01);
        chk({31'h0, fmode}, 32'h00000001);
        wr(8'h42, 8'h0D);
        repeat (2) @(negedge pclk);
        for (int i = 0; i < 8; i++) begin
            @(negedge pclk);
            sum += int'(fdv);
            ncar += int'(carry);
        end
        chk(32'(sum), 32'd82);
        chk(32'(ncar), 32'd2);
        wr(8'h42, 8'h0C);
        wr(8'h45, 8'h00);
        repeat (2) @(negedge pclk);
        chk({18'h0, carry, fdv}, 32'h0000000A);
        $display("test fractional divide done");
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mask();
        t_err();
        t_modes();
        t_frac();
        print_verdict();
    end
endmodule
